// ---- hdl/dcm_pkg.sv ----
// package: register map, fields and command codes of the sdram command block
package dcm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MODE_W = 14;

  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_MR_EMR1 = 8'h08;
  localparam logic [7:0] OFS_EMR2_3  = 8'h0C;
  localparam logic [7:0] OFS_CFG     = 8'h14;

  // command register fields
  localparam int unsigned BIT_INIT     = 0;
  localparam int unsigned BIT_MRS      = 1;
  localparam int unsigned BIT_SR_ENTER = 2;
  localparam int unsigned BIT_SR_EXIT  = 3;
  localparam int unsigned SEL_LSB      = 4;
  localparam int unsigned BIT_ZQCS     = 6;
  localparam int unsigned BIT_ZQCL     = 7;
  localparam int unsigned BIT_INIT_OK  = 8;
  localparam int unsigned BIT_INIT_ST  = 9;
  localparam int unsigned BIT_SR_ST    = 10;
  localparam int unsigned BIT_ZQCS_ST  = 12;
  localparam int unsigned BIT_ZQCL_ST  = 13;
  localparam int unsigned NUM_CMD      = 6;
  localparam int unsigned LO_LSB       = 0;
  localparam int unsigned HI_LSB       = 16;
  localparam int unsigned DLL_RST_BIT  = 8;
  localparam int unsigned CFG_DDR3_BIT = 0;

  localparam logic [31:0] RST_CMD   = 32'h0000_0000;
  localparam logic [31:0] RST_MODE  = 32'h0000_0000;
  localparam logic        RST_DDR3  = 1'b1;

  // one-hot pending command index
  localparam int unsigned CI_INIT = 0;
  localparam int unsigned CI_MRS  = 1;
  localparam int unsigned CI_SRE  = 2;
  localparam int unsigned CI_SRX  = 3;
  localparam int unsigned CI_ZQCS = 4;
  localparam int unsigned CI_ZQCL = 5;

  typedef enum logic [1:0] {
    MSEL_MR   = 2'b00,
    MSEL_EMR1 = 2'b01,
    MSEL_EMR2 = 2'b10,
    MSEL_EMR3 = 2'b11
  } dcm_msel_type;

  typedef enum logic [2:0] {
    SDOP_NOP  = 3'h0,
    SDOP_MRS  = 3'h1,
    SDOP_SRE  = 3'h2,
    SDOP_SRX  = 3'h3,
    SDOP_ZQCS = 3'h4,
    SDOP_ZQCL = 3'h5,
    SDOP_INIT = 3'h6
  } dcm_op_type;

  // request towards the sdram sequencer
  typedef struct packed {
    logic         valid;
    dcm_op_type   op;
    dcm_msel_type sel;
    logic [13:0]  value;
    logic         dll_reset;
  } dcm_req_type;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dcm_bus_type;

endpackage

// ---- hdl/dcm_arbiter.sv ----
// module: picks the lowest pending command bit, one at a time
`timescale 1ns/1ps
module dcm_arbiter #(
  parameter int unsigned N = 6
) (
  input  wire logic [N-1:0] pend_i,
  output logic      [N-1:0] grant_o
);
  always_comb begin
    grant_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        grant_o = '0;
        grant_o[i] = 1'b1;
      end
    end
  end
endmodule

// ---- hdl/dcm_ctrl.sv ----
// module: software command and mode register set control of the sdram controller
`timescale 1ns/1ps
module dcm_ctrl (
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [7:0]           bus_addr_i,
  input  wire logic [31:0]          bus_wdata_i,
  input  wire logic                 bus_wr_i,
  input  wire logic                 bus_rd_i,
  output logic      [31:0]          bus_rdata_o,
  output dcm_pkg::dcm_req_type      sd_req_o,
  input  wire logic                 sd_done_i,
  output logic                      ddr3_mode_o,
  output logic                      init_ok_o
);
  import dcm_pkg::*;

  // ***************************************************
  // state
  // ***************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ISSUE = 5'b00010,
    ST_WAIT  = 5'b00100,
    ST_INIT2 = 5'b01000,
    ST_INIT3 = 5'b10000
  } dcm_state_type;

  dcm_state_type        state;
  dcm_state_type        next_state;
  logic [NUM_CMD-1:0]   pend;
  logic [NUM_CMD-1:0]   next_pend;
  logic [NUM_CMD-1:0]   cur;
  logic [NUM_CMD-1:0]   next_cur;
  logic [NUM_CMD-1:0]   grant;
  logic [1:0]           msel;
  logic [1:0]           next_msel;
  logic [31:0]          mode_lo;
  logic [31:0]          next_mode_lo;
  logic [31:0]          mode_hi;
  logic [31:0]          next_mode_hi;
  logic                 ddr3;
  logic                 next_ddr3;
  logic                 init_ok;
  logic                 next_init_ok;
  logic                 in_init;
  logic                 next_in_init;
  logic                 in_sr;
  logic                 next_in_sr;
  logic                 in_zqcs;
  logic                 next_in_zqcs;
  logic                 in_zqcl;
  logic                 next_in_zqcl;
  logic [1:0]           istep;
  logic [1:0]           next_istep;
  dcm_req_type          req;
  dcm_req_type          next_req;
  logic [31:0]          rdata;
  logic [31:0]          next_rdata;
  logic [NUM_CMD-1:0]   wr_set;
  logic [NUM_CMD-1:0]   done_clr;

  // value field of one half of a mode value register
  function automatic logic [13:0] half_of(input logic [31:0] r, input logic hi);
    half_of = hi ? r[HI_LSB +: MODE_W] : r[LO_LSB +: MODE_W];
  endfunction

  // map command register write data onto pending vector
  function automatic logic [NUM_CMD-1:0] cmd_bits(input logic [31:0] d);
    cmd_bits = '0;
    cmd_bits[CI_INIT] = d[BIT_INIT];
    cmd_bits[CI_MRS]  = d[BIT_MRS];
    cmd_bits[CI_SRE]  = d[BIT_SR_ENTER];
    cmd_bits[CI_SRX]  = d[BIT_SR_EXIT];
    cmd_bits[CI_ZQCS] = d[BIT_ZQCS];
    cmd_bits[CI_ZQCL] = d[BIT_ZQCL];
  endfunction

  dcm_arbiter #(
    .N (NUM_CMD)
  ) u_arb (
    .pend_i  (pend),
    .grant_o (grant)
  );

  // ***************************************************
  // register writes
  // ***************************************************
  always_comb begin
    next_mode_lo = mode_lo;
    next_mode_hi = mode_hi;
    next_msel    = msel;
    next_ddr3    = ddr3;
    wr_set       = '0;
    if (bus_wr_i) begin
      case (bus_addr_i)
        OFS_CMD: begin
          next_msel = bus_wdata_i[SEL_LSB +: 2];
          wr_set    = cmd_bits(bus_wdata_i);
        end
        OFS_MR_EMR1: next_mode_lo = bus_wdata_i & 32'h3FFF_3FFF;
        OFS_EMR2_3:  next_mode_hi = bus_wdata_i & 32'h3FFF_3FFF;
        OFS_CFG:     next_ddr3 = bus_wdata_i[CFG_DDR3_BIT];
        default: begin
        end
      endcase
    end
    // zq commands are meaningless on ddr2
    if (!next_ddr3) begin
      wr_set[CI_ZQCS] = 1'b0;
      wr_set[CI_ZQCL] = 1'b0;
    end
  end

  // ***************************************************
  // command sequencing
  // ***************************************************
  assign done_clr = (state == ST_WAIT && sd_done_i) ? cur : '0;

  always_comb begin
    next_state   = state;
    next_cur     = cur;
    next_istep   = istep;
    next_init_ok = init_ok;
    next_in_init = in_init;
    next_in_sr   = in_sr;
    next_in_zqcs = in_zqcs;
    next_in_zqcl = in_zqcl;
    next_req     = req;
    next_req.valid = 1'b0;
    // set wins over completion clear
    next_pend = (pend & ~done_clr) | wr_set;
    case (state)
      ST_IDLE: begin
        if (|pend) begin
          next_cur   = grant;
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        next_req.valid     = 1'b1;
        next_req.dll_reset = 1'b0;
        next_req.sel       = dcm_msel_type'(msel);
        next_req.value     = '0;
        next_state         = ST_WAIT;
        case (1'b1)
          cur[CI_INIT]: begin
            next_req.op  = SDOP_MRS;
            next_req.sel = MSEL_EMR1;
            next_req.value = half_of(mode_lo, 1'b1);
            next_in_init = 1'b1;
            next_init_ok = 1'b0;
            next_istep   = 2'd0;
          end
          cur[CI_MRS]: begin
            next_req.op    = SDOP_MRS;
            next_req.value = half_of(msel[1] ? mode_hi : mode_lo, msel[0]);
          end
          cur[CI_SRE]: begin
            next_req.op = SDOP_SRE;
            next_in_sr  = 1'b1;
          end
          cur[CI_SRX]: next_req.op = SDOP_SRX;
          cur[CI_ZQCS]: begin
            next_req.op  = SDOP_ZQCS;
            next_in_zqcs = 1'b1;
          end
          cur[CI_ZQCL]: begin
            next_req.op  = SDOP_ZQCL;
            next_in_zqcl = 1'b1;
          end
          default: next_req.op = SDOP_NOP;
        endcase
      end
      ST_WAIT: begin
        if (sd_done_i) begin
          next_in_zqcs = 1'b0;
          next_in_zqcl = 1'b0;
          if (cur[CI_SRX]) begin
            next_in_sr = 1'b0;
          end
          if (cur[CI_INIT] && istep == 2'd0) begin
            next_pend  = next_pend | cur; // keep init pending through its steps
            next_state = ST_INIT2;
          end else if (cur[CI_INIT] && istep == 2'd1) begin
            next_pend  = next_pend | cur;
            next_state = ST_INIT3;
          end else begin
            if (cur[CI_INIT]) begin
              next_in_init = 1'b0;
              next_init_ok = 1'b1;
            end
            next_cur   = '0;
            next_state = ST_IDLE;
          end
        end
      end
      ST_INIT2: begin
        // mr with dll reset forced high regardless of software value
        next_req.valid     = 1'b1;
        next_req.op        = SDOP_MRS;
        next_req.sel       = MSEL_MR;
        next_req.value     = half_of(mode_lo, 1'b0);
        next_req.value[DLL_RST_BIT] = 1'b1;
        next_istep = 2'd1;
        next_state = ST_WAIT;
      end
      ST_INIT3: begin
        // final phase: phy compensation calibration and zq init
        next_req.valid     = 1'b1;
        next_req.op        = SDOP_INIT;
        next_req.sel       = MSEL_MR;
        next_req.value     = '0;
        next_req.dll_reset = 1'b0;
        next_istep = 2'd2;
        next_state = ST_WAIT;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ***************************************************
  // read data
  // ***************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus_rd_i) begin
      case (bus_addr_i)
        OFS_CMD: begin
          next_rdata[BIT_INIT]          = pend[CI_INIT];
          next_rdata[BIT_MRS]           = pend[CI_MRS];
          next_rdata[BIT_SR_ENTER]      = pend[CI_SRE];
          next_rdata[BIT_SR_EXIT]       = pend[CI_SRX];
          next_rdata[SEL_LSB +: 2]      = msel;
          next_rdata[BIT_ZQCS]          = pend[CI_ZQCS];
          next_rdata[BIT_ZQCL]          = pend[CI_ZQCL];
          next_rdata[BIT_INIT_OK]       = init_ok;
          next_rdata[BIT_INIT_ST]       = in_init;
          next_rdata[BIT_SR_ST]         = in_sr;
          next_rdata[BIT_ZQCS_ST]       = in_zqcs;
          next_rdata[BIT_ZQCL_ST]       = in_zqcl;
        end
        OFS_MR_EMR1: next_rdata = mode_lo;
        OFS_EMR2_3:  next_rdata = mode_hi;
        OFS_CFG:     next_rdata[CFG_DDR3_BIT] = ddr3;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state   <= ST_IDLE;
      pend    <= '0;
      cur     <= '0;
      msel    <= 2'b00;
      mode_lo <= RST_MODE;
      mode_hi <= RST_MODE;
      ddr3    <= RST_DDR3;
      init_ok <= 1'b0;
      in_init <= 1'b0;
      in_sr   <= 1'b0;
      in_zqcs <= 1'b0;
      in_zqcl <= 1'b0;
      istep   <= 2'd0;
      req     <= '0;
      rdata   <= RST_CMD;
    end else begin
      state   <= next_state;
      pend    <= next_pend;
      cur     <= next_cur;
      msel    <= next_msel;
      mode_lo <= next_mode_lo;
      mode_hi <= next_mode_hi;
      ddr3    <= next_ddr3;
      init_ok <= next_init_ok;
      in_init <= next_in_init;
      in_sr   <= next_in_sr;
      in_zqcs <= next_in_zqcs;
      in_zqcl <= next_in_zqcl;
      istep   <= next_istep;
      req     <= next_req;
      rdata   <= next_rdata;
    end
  end

  assign bus_rdata_o = rdata;
  assign sd_req_o    = req;
  assign ddr3_mode_o = ddr3;
  assign init_ok_o   = init_ok;
endmodule

// ---- bench/dcm_ctrl_monitor.sv ----
// checker: port level properties of the sdram command block
`timescale 1ns/1ps
module dcm_ctrl_monitor
  import dcm_pkg::*;
(
  input wire logic                 clk_sys_i,
  input wire logic                 sys_rst_i,
  input wire logic [7:0]           bus_addr_i,
  input wire logic [31:0]          bus_wdata_i,
  input wire logic                 bus_wr_i,
  input wire logic                 bus_rd_i,
  input wire logic [31:0]          bus_rdata_o,
  input wire dcm_pkg::dcm_req_type sd_req_o,
  input wire logic                 sd_done_i,
  input wire logic                 ddr3_mode_o,
  input wire logic                 init_ok_o
);
  // ************
  // value shadows
  // ************
  logic [31:0] sh_lo;
  logic [31:0] sh_hi;
  logic [31:0] next_sh_lo;
  logic [31:0] next_sh_hi;
  logic        mrs_req;

  assign mrs_req = sd_req_o.valid && sd_req_o.op == SDOP_MRS;

  // shadows follow bus writes so values can be compared without peeking inside
  always_comb begin
    next_sh_lo = sh_lo;
    next_sh_hi = sh_hi;
    if (bus_wr_i && bus_addr_i == OFS_MR_EMR1) next_sh_lo = bus_wdata_i;
    if (bus_wr_i && bus_addr_i == OFS_EMR2_3) next_sh_hi = bus_wdata_i;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_lo <= RST_MODE;
      sh_hi <= RST_MODE;
    end else begin
      sh_lo <= next_sh_lo;
      sh_hi <= next_sh_hi;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // ************
  // properties
  // ************
  AST_ZQ_DDR3_ONLY: assert property (
    !ddr3_mode_o && sd_req_o.valid |-> !(sd_req_o.op inside {SDOP_ZQCS, SDOP_ZQCL}))
    else $error("zq request issued in ddr2 mode");
  AST_MRS_MR_VALUE: assert property (
    mrs_req && sd_req_o.sel == MSEL_MR |->
      {sd_req_o.value[13:9], sd_req_o.value[7:0]} == {sh_lo[13:9], sh_lo[7:0]})
    else $error("mr value does not match low half");
  AST_MRS_EXT1_VALUE: assert property (
    mrs_req && sd_req_o.sel == MSEL_EMR1 |-> sd_req_o.value == sh_lo[29:16])
    else $error("emr1 value does not match high half");
  AST_MRS_EXT23_VALUE: assert property (
    mrs_req && sd_req_o.sel[1] |->
      sd_req_o.value == (sd_req_o.sel[0] ? sh_hi[29:16] : sh_hi[13:0]))
    else $error("emr2 or emr3 value wrong");
  AST_INIT_DLL_RESET: assert property (
    mrs_req && sd_req_o.sel == MSEL_MR && !init_ok_o |-> sd_req_o.value[DLL_RST_BIT])
    else $error("dll reset not driven during init");
  AST_ONE_AT_A_TIME: assert property (
    sd_req_o.valid |=> !sd_req_o.valid [*2])
    else $error("requests too close together");
  AST_INIT_OK_CAUSE: assert property (
    $rose(init_ok_o) |-> $past(sd_done_i) || $past(sd_done_i, 2))
    else $error("init done set without a completion");
  // a new init run clears it together with its first request
  AST_INIT_OK_HOLDS: assert property (
    init_ok_o |=> init_ok_o || (mrs_req && sd_req_o.sel == MSEL_EMR1))
    else $error("init done dropped");
endmodule

bind dcm_ctrl dcm_ctrl_monitor mon_u (
  .clk_sys_i   (clk_sys_i),
  .sys_rst_i   (sys_rst_i),
  .bus_addr_i  (bus_addr_i),
  .bus_wdata_i (bus_wdata_i),
  .bus_wr_i    (bus_wr_i),
  .bus_rd_i    (bus_rd_i),
  .bus_rdata_o (bus_rdata_o),
  .sd_req_o    (sd_req_o),
  .sd_done_i   (sd_done_i),
  .ddr3_mode_o (ddr3_mode_o),
  .init_ok_o   (init_ok_o)
);

// ---- bench/dcm_sdram_model.sv ----
// model: sdram sequencer stand-in answering each request after a set delay
`timescale 1ns/1ps
module dcm_sdram_model (
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire dcm_pkg::dcm_req_type req_i,
  input  wire logic [7:0]           delay_i,
  output logic                      done_o
);
  import dcm_pkg::*;
  logic [7:0] cnt;

  // one request in flight; delay_i picks a prompt or a slow answer
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt    <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 8'h01);
      if (req_i.valid) cnt <= delay_i;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
  end
endmodule

// ---- bench/dcm_ctrl_tb.sv ----
// testbench: register driven sdram commands of the command block
`timescale 1ns/1ps
module dcm_ctrl_tb;
  import dcm_pkg::*;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic [7:0]  bus_addr_i;
  logic [31:0] bus_wdata_i;
  logic        bus_wr_i;
  logic        bus_rd_i;
  logic [31:0] bus_rdata_o;
  dcm_req_type sd_req_o;
  logic        sd_done_i;
  logic        ddr3_mode_o;
  logic        init_ok_o;
  logic [7:0]  dly;
  logic [31:0] d;
  int          errors;
  int          n_checks;
  logic [13:0] exp_tab [4] = '{14'h0A44, 14'h0123, 14'h2DEF, 14'h1ABC};

  always #4 clk_sys_i = ~clk_sys_i;

  dcm_ctrl dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .sd_req_o(sd_req_o), .sd_done_i(sd_done_i),
    .ddr3_mode_o(ddr3_mode_o), .init_ok_o(init_ok_o));
  dcm_sdram_model mdl_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(sd_req_o),
    .delay_i(dly), .done_o(sd_done_i));

  // ************
  // tasks
  // ************
  task automatic results();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    bus_addr_i  <= a;
    bus_wdata_i <= v;
    bus_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    bus_addr_i <= a;
    bus_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    bus_rd_i <= 1'b0;
    #1;
    d = bus_rdata_o;
  endtask
  // bounded wait for the next request, then step past its one cycle pulse
  task automatic exp_req(input logic [2:0] op, input logic [1:0] sel, input logic [13:0] v);
    int k;
    k = 0;
    while (sd_req_o.valid !== 1'b1 && k < 200) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    chk("req_valid", {31'h0, sd_req_o.valid}, 32'h1);
    chk("req_op", {29'h0, sd_req_o.op}, {29'h0, op});
    if (op == SDOP_MRS) begin
      chk("req_sel", {30'h0, sd_req_o.sel}, {30'h0, sel});
      chk("req_value", {18'h0, sd_req_o.value}, {18'h0, v});
    end
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (sd_done_i !== 1'b1 && k < 200) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    chk("done_seen", {31'h0, sd_done_i}, 32'h1);
    // one edge only: the next init step is requested two edges after done
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic no_req(input string name);
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      @(posedge clk_sys_i);
      #1;
      seen |= (sd_req_o.valid === 1'b1);
    end
    chk(name, {31'h0, seen}, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    results();
  end

  // ************
  // tests
  // ************
  initial begin
    clk_sys_i = 1'b0; sys_rst_i = 1'b1; bus_addr_i = 8'h00; bus_wdata_i = 32'h0;
    bus_wr_i = 1'b0; bus_rd_i = 1'b0; dly = 8'd3; errors = 0; n_checks = 0;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(OFS_CMD);      chk("cmd_reset", d, RST_CMD);
    rd(OFS_MR_EMR1);  chk("mr_emr1_reset", d, RST_MODE);
    rd(OFS_EMR2_3);   chk("emr2_3_reset", d, RST_MODE);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);        chk("unmapped", d, 32'h0000_0000);
    // values loaded before any mode set; additive latency field left zero
    // mr: burst length 8 fixed, sequential; dqs select bit 26 left zero
    wr(OFS_MR_EMR1, 32'h0123_0A44);
    wr(OFS_EMR2_3, 32'h1ABC_2DEF);
    rd(OFS_MR_EMR1);  chk("mr_emr1_rw", d, 32'h0123_0A44);
    rd(OFS_EMR2_3);   chk("emr2_3_rw", d, 32'h1ABC_2DEF);
    dly = 8'd12;
    wr(OFS_CMD, 32'h0000_0001);
    exp_req(SDOP_MRS, MSEL_EMR1, 14'h0123);
    rd(OFS_CMD);      chk("init_pending", d & 32'h0000_0101, 32'h0000_0001);
    wait_done();
    exp_req(SDOP_MRS, MSEL_MR, 14'h0B44);
    wait_done();
    exp_req(SDOP_INIT, MSEL_MR, 14'h0000);
    wait_done();
    chk("init_ok", {31'h0, init_ok_o}, 32'h1);
    rd(OFS_CMD);      chk("init_clear", d & 32'h0000_0101, 32'h0000_0100);
    dly = 8'd3;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CMD, {26'h0, s[1:0], 4'b0010});
      exp_req(SDOP_MRS, s[1:0], exp_tab[s]);
      wait_done();
      rd(OFS_CMD);    chk("mrs_clear", d & 32'h0000_0002, 32'h0);
    end
    wr(OFS_CMD, 32'h0000_0000);
    no_req("zero_write");
    dly = 8'd12;
    wr(OFS_CMD, 32'h0000_000C);
    exp_req(SDOP_SRE, MSEL_MR, 14'h0000);
    exp_req(SDOP_SRX, MSEL_MR, 14'h0000);
    rd(OFS_CMD);      chk("sr_state", d & 32'h0000_040C, 32'h0000_0408);
    wait_done();
    rd(OFS_CMD);      chk("sr_exit", d & 32'h0000_0408, 32'h0);
    wr(OFS_CMD, 32'h0000_0040);
    exp_req(SDOP_ZQCS, MSEL_MR, 14'h0000);
    wait_done();
    wr(OFS_CMD, 32'h0000_0080);
    exp_req(SDOP_ZQCL, MSEL_MR, 14'h0000);
    rd(OFS_CMD);      chk("zqcl_state", d & 32'h0000_2080, 32'h0000_2080);
    wait_done();
    rd(OFS_CMD);      chk("zqcl_clear", d & 32'h0000_2080, 32'h0);
    // ddr2 operation: zq requests are dropped
    wr(OFS_CFG, 32'h0000_0000);
    @(posedge clk_sys_i);
    #1;
    chk("ddr2_mode", {31'h0, ddr3_mode_o}, 32'h0);
    wr(OFS_CMD, 32'h0000_00C0);
    no_req("zq_in_ddr2");
    rd(OFS_CMD);      chk("zq_ddr2_bit", d & 32'h0000_00C0, 32'h0);
    wr(OFS_CFG, 32'h0000_0001);
    // mid-run reset: status, values and mode return to their reset state
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rst_ddr3", {31'h0, ddr3_mode_o}, {31'h0, RST_DDR3});
    chk("rst_init_ok", {31'h0, init_ok_o}, 32'h0);
    rd(OFS_MR_EMR1);  chk("mr_emr1_rst2", d, RST_MODE);
    rd(OFS_CFG);      chk("cfg_rst", d, {31'h0, RST_DDR3});
    @(posedge clk_sys_i);
    #1;
    chk("rdata_idle", bus_rdata_o, 32'h0000_0000);
    results();
  end
endmodule
